// ==== verilog/mra_consts.vh ====
// Constants for the monitor result and alert register bank.
// Assumes inclusion by bare name from design files.
`ifndef MRA_CONSTS_VH
`define MRA_CONSTS_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define MRA_ADDR_TEMP      8'h06
`define MRA_ADDR_CURRENT   8'h07
`define MRA_ADDR_POWER     8'h08
`define MRA_ADDR_DIAG      8'h0b
// ----------------------------------------
// Diagnostic register field positions
// ----------------------------------------
`define MRA_BIT_HOLD       15
`define MRA_BIT_RDY_EN     14
`define MRA_BIT_AVG_CMP    13
`define MRA_BIT_SENSE      12
`define MRA_BIT_OVF        9
`define MRA_BIT_TEMP_HI    7
`define MRA_BIT_SHUNT_HI   6
`define MRA_BIT_SHUNT_LO   5
`define MRA_BIT_BUS_HI     4
`define MRA_BIT_BUS_LO     3
`define MRA_BIT_PWR_HI     2
`define MRA_BIT_DONE       1
`define MRA_BIT_TRIM_OK    0
// ----------------------------------------
// Reset values
// ----------------------------------------
`define MRA_RST_DIAG       16'h0001
`define MRA_RST_RESULT     24'h000000
// ----------------------------------------
// Timing: no long counts in this block
// ----------------------------------------
`define MRA_SYNC_STAGES    2
`endif

// ==== verilog/mra_sync.v ====
// Two flip-flop synchroniser for a vector of asynchronous levels.
// Assumes the inputs come from outside the core clock domain.
`timescale 1ns/1ns
`default_nettype none
module mra_sync #(
  parameter WIDTH = 1
) (
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire [WIDTH-1:0] d_i,
  output reg  [WIDTH-1:0] q_o
);
  reg [WIDTH-1:0] stage1;

  always @(posedge clk_i) begin
    if (rst_i) begin
      stage1 <= {WIDTH{1'b0}};
      q_o    <= {WIDTH{1'b0}};
    end else begin
      stage1 <= d_i;
      q_o    <= stage1;
    end
  end
endmodule
`default_nettype wire

// ==== verilog/mra_regs.v ====
// Result and diagnostic/alert register bank of a digital power monitor.
// Assumes a serial-interface engine on CORE_CLK_I issues single-cycle read
// and write strobes, and the measurement engine gives same-clock pulses.
// Trim checksum error arrives asynchronously and is synchronised.
`timescale 1ns/1ns
`default_nettype none
`include "mra_consts.vh"
module mra_regs #(
  parameter ADDR_W = 8
) (
  input  wire              CORE_CLK_I,
  input  wire              RESET_I,
  // Register access from the serial interface engine
  input  wire [ADDR_W-1:0] REG_ADDR_I,
  input  wire              REG_RD_I,
  input  wire              REG_WR_I,
  input  wire [15:0]       REG_WDATA_I,
  output reg  [23:0]       REG_RDATA_O,
  output reg               REG_RVALID_O,
  // Results from the arithmetic engine
  input  wire              RESULT_LOAD_I,
  input  wire [11:0]       TEMP_RESULT_I,
  input  wire [15:0]       CURRENT_RESULT_I,
  input  wire [23:0]       POWER_RESULT_I,
  input  wire              ARITH_OVERFLOW_I,
  // Comparator outcomes: raw sample strobe and averaged strobe
  input  wire              RAW_CMP_VALID_I,
  input  wire              AVG_CMP_VALID_I,
  input  wire [5:0]        CMP_VALID_MASK_I,
  input  wire [5:0]        CMP_EXCEED_I,
  input  wire              CONV_DONE_I,
  input  wire              CONV_START_I,
  input  wire              TRIM_CSUM_ERR_I,
  // Open-drain alert pin: enable low drives the pin low
  output reg               ALERT_O,
  output reg               ALERT_OE_N_O
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  reg  [11:0] die_temperature_field;
  reg  [15:0] current_result;
  reg  [23:0] power_result;
  reg         alert_hold_select;
  reg         ready_to_alert_enable;
  reg         averaged_compare_select;
  reg         alert_output_sense;
  reg         arith_overflow_flag;
  reg  [5:0]  limit_flags;
  reg         conversion_done_flag;
  reg         trim_checksum_ok;
  wire        csum_err_sync;
  wire [15:0] diagnostic_alert_register;
  wire        cmp_strobe;
  wire        rd_diag;
  wire        wr_diag;
  reg  [5:0]  next_limit_flags;
  reg         next_done;
  reg         next_active;
  reg         next_hold;
  reg         next_rdy_en;
  reg         next_avg;
  reg         next_sense;
  reg         next_overflow;
  reg         next_trim_ok;
  reg         next_oe_n;
  reg  [23:0] next_rdata;
  wire        sel_temp;
  wire        sel_current;
  wire        sel_power;
  wire        sel_diag;
  wire        temp_high_flag;
  wire        shunt_high_flag;
  wire        shunt_low_flag;
  wire        bus_high_flag;
  wire        bus_low_flag;
  wire        power_high_flag;

  mra_sync #(
    .WIDTH (1)
  ) u_csum_sync (
    .clk_i (CORE_CLK_I),
    .rst_i (RESET_I),
    .d_i   (TRIM_CSUM_ERR_I),
    .q_o   (csum_err_sync)
  );

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // One compare per register, shared by read select and strobes
  assign sel_temp    = (REG_ADDR_I == `MRA_ADDR_TEMP);
  assign sel_current = (REG_ADDR_I == `MRA_ADDR_CURRENT);
  assign sel_power   = (REG_ADDR_I == `MRA_ADDR_POWER);
  assign sel_diag    = (REG_ADDR_I == `MRA_ADDR_DIAG);
  assign rd_diag     = REG_RD_I && sel_diag;
  assign wr_diag     = REG_WR_I && sel_diag;

  // Averaged comparisons arrive later, so with averaged select set, limit alerts wait for averaging
  assign cmp_strobe = averaged_compare_select ? AVG_CMP_VALID_I : RAW_CMP_VALID_I;

  // ----------------------------------------
  // Diagnostic register view
  // ----------------------------------------
  // Named views of the flag vector, bit5 temp down to bit0 power
  assign temp_high_flag  = limit_flags[5];
  assign shunt_high_flag = limit_flags[4];
  assign shunt_low_flag  = limit_flags[3];
  assign bus_high_flag   = limit_flags[2];
  assign bus_low_flag    = limit_flags[1];
  assign power_high_flag = limit_flags[0];
  assign diagnostic_alert_register = {alert_hold_select,
                                      ready_to_alert_enable,
                                      averaged_compare_select,
                                      alert_output_sense,
                                      2'b00,
                                      arith_overflow_flag,
                                      1'b0,
                                      temp_high_flag,
                                      shunt_high_flag,
                                      shunt_low_flag,
                                      bus_high_flag,
                                      bus_low_flag,
                                      power_high_flag,
                                      conversion_done_flag,
                                      trim_checksum_ok};

  // ----------------------------------------
  // Result registers
  // ----------------------------------------
  // All three load together so a read never mixes two conversions
  always @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      die_temperature_field <= 12'h000;
      current_result        <= 16'h0000;
      power_result          <= `MRA_RST_RESULT;
    end else if (RESULT_LOAD_I) begin
      die_temperature_field <= TEMP_RESULT_I;
      current_result        <= CURRENT_RESULT_I;
      power_result          <= POWER_RESULT_I;
    end
  end

  // ----------------------------------------
  // Control field next-state
  // ----------------------------------------
  // Only bits 15-12 take host writes; flag bits are hardware owned
  always @* begin
    next_hold   = alert_hold_select;
    next_rdy_en = ready_to_alert_enable;
    next_avg    = averaged_compare_select;
    next_sense  = alert_output_sense;
    if (wr_diag) begin
      next_hold   = REG_WDATA_I[`MRA_BIT_HOLD];
      next_rdy_en = REG_WDATA_I[`MRA_BIT_RDY_EN];
      next_avg    = REG_WDATA_I[`MRA_BIT_AVG_CMP];
      next_sense  = REG_WDATA_I[`MRA_BIT_SENSE];
    end
  end

  // ----------------------------------------
  // Flag next-state
  // ----------------------------------------
  // Hardware set beats a read clear in the same cycle.
  always @* begin
    next_limit_flags = limit_flags;
    next_done        = conversion_done_flag;
    if (alert_hold_select) begin
      if (rd_diag) begin
        next_limit_flags = 6'h00;
        next_done        = 1'b0;
      end
      if (CONV_START_I)
        next_done = 1'b0;
      if (cmp_strobe)
        next_limit_flags = next_limit_flags | (CMP_EXCEED_I & CMP_VALID_MASK_I);
      if (CONV_DONE_I)
        next_done = 1'b1;
    end else begin
      // Each flag tracks only the measurements compared this time
      if (cmp_strobe)
        next_limit_flags = (limit_flags & ~CMP_VALID_MASK_I)
                         | (CMP_EXCEED_I & CMP_VALID_MASK_I);
      if (CONV_START_I)
        next_done = 1'b0;
      if (CONV_DONE_I)
        next_done = 1'b1;
    end
    next_active = (|next_limit_flags) || (ready_to_alert_enable && next_done);
  end

  // ----------------------------------------
  // Status and alert next-state
  // ----------------------------------------
  // Overflow clears only on a new conversion; a load with overflow wins
  always @* begin
    next_overflow = arith_overflow_flag;
    if (CONV_START_I)
      next_overflow = 1'b0;
    if (RESULT_LOAD_I && ARITH_OVERFLOW_I)
      next_overflow = 1'b1;
  end

  // Sticky until reset: software cannot undo a trim fault
  always @* begin
    next_trim_ok = trim_checksum_ok;
    if (csum_err_sync)
      next_trim_ok = 1'b0;
  end

  // Pin only ever pulled low; active-high sense releases when asserted.
  // Built from the next flags so the pin moves with the bit it reports.
  always @* begin
    next_oe_n = ~(next_active ^ alert_output_sense);
  end

  // ----------------------------------------
  // Diagnostic register and alert pin
  // ----------------------------------------
  always @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      alert_hold_select       <= 1'b0;
      ready_to_alert_enable   <= 1'b0;
      averaged_compare_select <= 1'b0;
      alert_output_sense      <= 1'b0;
      arith_overflow_flag     <= 1'b0;
      limit_flags             <= 6'h00;
      conversion_done_flag    <= 1'b0;
      trim_checksum_ok        <= 1'b1;
      ALERT_O                 <= 1'b0;
      ALERT_OE_N_O            <= 1'b1;
    end else begin
      alert_hold_select       <= next_hold;
      ready_to_alert_enable   <= next_rdy_en;
      averaged_compare_select <= next_avg;
      alert_output_sense      <= next_sense;
      arith_overflow_flag     <= next_overflow;
      limit_flags             <= next_limit_flags;
      conversion_done_flag    <= next_done;
      trim_checksum_ok        <= next_trim_ok;
      ALERT_O                 <= 1'b0;
      ALERT_OE_N_O            <= next_oe_n;
    end
  end

  // ----------------------------------------
  // Read data select
  // ----------------------------------------
  // Unmapped addresses read zero rather than a stale word
  always @* begin
    if (sel_temp)
      next_rdata = {8'h00, die_temperature_field, 4'h0};
    else if (sel_current)
      next_rdata = {8'h00, current_result};
    else if (sel_power)
      next_rdata = power_result;
    else if (sel_diag)
      next_rdata = {8'h00, diagnostic_alert_register};
    else
      next_rdata = 24'h000000;
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      REG_RDATA_O  <= 24'h000000;
      REG_RVALID_O <= 1'b0;
    end else begin
      REG_RVALID_O <= REG_RD_I;
      // Data holds between reads so a slow host can pick it up late
      if (REG_RD_I)
        REG_RDATA_O <= next_rdata;
    end
  end
endmodule
`default_nettype wire

// ==== test/mra_regs_chk.sv ====
// Port checker for the result and alert register bank.
// Bound to mra_regs; learns the control bits by watching writes.
`timescale 1ns/1ns
`default_nettype none
module mra_regs_chk #(
  parameter ADDR_W = 8
) (
  input wire logic              CORE_CLK_I,
  input wire logic              RESET_I,
  input wire logic [ADDR_W-1:0] REG_ADDR_I,
  input wire logic              REG_RD_I,
  input wire logic              REG_WR_I,
  input wire logic [15:0]       REG_WDATA_I,
  input wire logic [23:0]       REG_RDATA_O,
  input wire logic              REG_RVALID_O,
  input wire logic              RAW_CMP_VALID_I,
  input wire logic              AVG_CMP_VALID_I,
  input wire logic [5:0]        CMP_VALID_MASK_I,
  input wire logic [5:0]        CMP_EXCEED_I,
  input wire logic              CONV_DONE_I,
  input wire logic              CONV_START_I,
  input wire logic              ALERT_OE_N_O
);
  // Hold, ready enable, averaged select, sense
  logic [3:0] ctl;
  always @(posedge CORE_CLK_I)
    if (RESET_I)
      ctl <= 4'h0;
    else if (REG_WR_I && REG_ADDR_I == 8'h0b)
      ctl <= REG_WDATA_I[15:12];
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (RESET_I);
  read_answer_a: assert property (REG_RD_I |=> REG_RVALID_O)
    else $error("read not answered");
  temp_nibble_a: assert property (REG_RD_I && REG_ADDR_I == 8'h06 |=> (REG_RDATA_O & 24'hff000f) == 0)
    else $error("temperature low bits set");
  diag_reserved_a: assert property (REG_RD_I && REG_ADDR_I == 8'h0b |=> (REG_RDATA_O & 24'hff0d00) == 0)
    else $error("reserved bits set");
  raw_alert_a: assert property (!REG_WR_I && !ctl[1] && RAW_CMP_VALID_I && |(CMP_VALID_MASK_I & CMP_EXCEED_I)
    |=> ALERT_OE_N_O == ctl[0]) else $error("raw fault gave no alert");
  avg_defer_a: assert property (!REG_WR_I && ctl == 4'h2 && RAW_CMP_VALID_I && !AVG_CMP_VALID_I && !CONV_DONE_I
    && !CONV_START_I && $stable(ctl) |=> $stable(ALERT_OE_N_O)) else $error("raw sample moved averaged alert");
  latch_hold_a: assert property (ctl[3] && $stable(ctl) && ALERT_OE_N_O == ctl[0] && !REG_RD_I && !REG_WR_I
    && !CONV_START_I |=> ALERT_OE_N_O == ctl[0]) else $error("latched alert dropped");
  ready_alert_a: assert property (ctl[2] && CONV_DONE_I && !CONV_START_I && !REG_WR_I |=> ALERT_OE_N_O == ctl[0])
    else $error("ready gave no alert");
  clear_idle_a: assert property (ctl[3:1] == 3'h0 && !REG_WR_I && RAW_CMP_VALID_I && CMP_VALID_MASK_I == 6'h3f
    && CMP_EXCEED_I == 6'h00 |=> ALERT_OE_N_O != ctl[0]) else $error("alert stayed after clear");
  cover property (ctl[3] && REG_RD_I && REG_ADDR_I == 8'h0b);
  cover property (ctl[1] && AVG_CMP_VALID_I);
  cover property (ctl[2] && CONV_DONE_I);
endmodule
bind mra_regs mra_regs_chk #(.ADDR_W(ADDR_W)) chk (.*);
`default_nettype wire

// ==== test/mra_host.sv ====
// Serial host model issuing single-cycle register strobes.
// Requests launch just after a rising edge of the core clock.
`timescale 1ns/1ns
`default_nettype none
module mra_host (
  input  wire logic        clk_i,
  input  wire logic [23:0] rdata_i,
  input  wire logic        rvalid_i,
  output var  logic [7:0]  addr_o,
  output var  logic        rd_o,
  output var  logic        wr_o,
  output var  logic [15:0] wdata_o
);
  initial begin
    addr_o = 8'h00;
    rd_o = 1'b0;
    wr_o = 1'b0;
    wdata_o = 16'h0000;
  end
  // Released lines show the inverse, so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [23:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    @(posedge clk_i);
    d = rvalid_i ? rdata_i : 24'hxxxxxx;
  endtask
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
// Self-checking bench for the result and alert register bank.
// The host model reads registers; the bench plays the measurement engine.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("unexpected %s exp %h got %h", n, e, a); end end
module testbench;
  logic clk = 1'b0, rst = 1'b1, rd, wr, rvalid, alert, oe_n;
  logic ld = 1'b0, raw = 1'b0, avg = 1'b0, dn = 1'b0, st = 1'b0, ovf = 1'b0, trim = 1'b0;
  logic [7:0] addr;
  logic [15:0] wdata, c = 16'h0000;
  logic [23:0] rdata, d, p = 24'h000000;
  logic [11:0] t = 12'h000;
  logic [5:0] mask = 6'h00, exc = 6'h00;
  int n_mismatch = 0, n_checks = 0, cyc = 0;
  localparam logic [4:0] LD = 5'h10, RW = 5'h08, AV = 5'h04, DN = 5'h02, ST = 5'h01;
  mra_host host (.clk_i(clk), .rdata_i(rdata), .rvalid_i(rvalid), .addr_o(addr), .rd_o(rd), .wr_o(wr),
    .wdata_o(wdata));
  mra_regs dut (.CORE_CLK_I(clk), .RESET_I(rst), .REG_ADDR_I(addr), .REG_RD_I(rd), .REG_WR_I(wr),
    .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .RESULT_LOAD_I(ld),
    .TEMP_RESULT_I(t), .CURRENT_RESULT_I(c), .POWER_RESULT_I(p), .ARITH_OVERFLOW_I(ovf),
    .RAW_CMP_VALID_I(raw), .AVG_CMP_VALID_I(avg), .CMP_VALID_MASK_I(mask), .CMP_EXCEED_I(exc),
    .CONV_DONE_I(dn), .CONV_START_I(st), .TRIM_CSUM_ERR_I(trim), .ALERT_O(alert), .ALERT_OE_N_O(oe_n));
  initial forever #20 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Engine strobes last one cycle; the extra edge lets the alert settle
  task automatic ev(input logic [4:0] s, input logic [5:0] m, input logic [5:0] e);
    @(posedge clk);
    {ld, raw, avg, dn, st} <= s;
    mask <= m;
    exc <= e;
    @(posedge clk);
    {ld, raw, avg, dn, st} <= 5'h00;
    @(posedge clk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [23:0] e);
    host.rd(a, d);
    `CHK("rdata", e, d)
  endtask
  task automatic t_results();
    t <= 12'h800;
    c <= 16'h8001;
    p <= 24'hfedcba;
    ovf <= 1'b1;
    ev(LD, 6'h00, 6'h00);
    ovf <= 1'b0;
    rc(8'h06, 24'h008000);
    rc(8'h07, 24'h008001);
    rc(8'h08, 24'hfedcba);
    host.wr(8'h06, 16'hffff);
    rc(8'h06, 24'h008000);
    rc(8'h20, 24'h000000);
    rc(8'h0b, 24'h000201);
    rc(8'h0b, 24'h000201);
    ev(ST, 6'h00, 6'h00);
    rc(8'h0b, 24'h000001);
    ovf <= 1'b1;
    ev(LD | ST, 6'h00, 6'h00);
    ovf <= 1'b0;
    rc(8'h0b, 24'h000201);
    ev(ST, 6'h00, 6'h00);
    rc(8'h0b, 24'h000001);
  endtask
  task automatic t_flags();
    for (int i = 0; i < 6; i++) begin
      ev(RW, 6'h3f, 6'h01 << i);
      `CHK("alert_oe_n", 1'b0, oe_n)
      rc(8'h0b, 24'h000001 | (24'h000004 << i));
    end
    ev(RW, 6'h21, 6'h01);
    ev(RW, 6'h20, 6'h20);
    rc(8'h0b, 24'h000085);
    ev(RW, 6'h20, 6'h00);
    rc(8'h0b, 24'h000005);
    ev(RW, 6'h3f, 6'h00);
    `CHK("alert_oe_n", 1'b1, oe_n)
    `CHK("alert", 1'b0, alert)
    rc(8'h0b, 24'h000001);
  endtask
  task automatic t_latch();
    host.wr(8'h0b, 16'h8000);
    ev(RW, 6'h20, 6'h20);
    ev(RW, 6'h3f, 6'h00);
    `CHK("alert_oe_n", 1'b0, oe_n)
    rc(8'h0b, 24'h008081);
    rc(8'h0b, 24'h008001);
    `CHK("alert_oe_n", 1'b1, oe_n)
    ev(DN, 6'h00, 6'h00);
    rc(8'h0b, 24'h008003);
    rc(8'h0b, 24'h008001);
    ev(DN, 6'h00, 6'h00);
    ev(ST, 6'h00, 6'h00);
    rc(8'h0b, 24'h008001);
  endtask
  task automatic t_ready();
    host.wr(8'h0b, 16'h5000);
    rc(8'h0b, 24'h005001);
    `CHK("alert_oe_n", 1'b0, oe_n)
    ev(DN, 6'h00, 6'h00);
    `CHK("alert_oe_n", 1'b1, oe_n)
    rc(8'h0b, 24'h005003);
    ev(ST, 6'h00, 6'h00);
    `CHK("alert_oe_n", 1'b0, oe_n)
  endtask
  task automatic t_avg();
    host.wr(8'h0b, 16'h2000);
    ev(RW, 6'h20, 6'h20);
    `CHK("alert_oe_n", 1'b1, oe_n)
    ev(AV, 6'h20, 6'h20);
    `CHK("alert_oe_n", 1'b0, oe_n)
    rc(8'h0b, 24'h002081);
    ev(AV, 6'h3f, 6'h00);
    trim <= 1'b1;
    repeat (4) @(posedge clk);
    rc(8'h0b, 24'h002000);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rc(8'h0b, 24'h000001);
    rc(8'h08, 24'h000000);
    t_results();
    t_flags();
    t_latch();
    t_ready();
    t_avg();
    give_verdict();
  end
endmodule
`default_nettype wire
